//--- design/sbdig_top.sv
/*
 Board glue for a four-port serial card on an 8-bit PC/104 I/O bus:
 baud clock select, address decode, half-duplex control, shared
 interrupt drive and the read-only interrupt status register.
 Assumes straps are static, bus pins and oscillator are asynchronous
 to mclk and are sampled through two flip-flops.
*/
// Behaviour
// - Clock strap out: oscillator divided by four feeds the serial controllers.
// - Clock strap in: oscillator passed undivided for four times the rate.
// - Auto half-duplex: request-to-send low while data pending, high after.
// - One strap sets auto control for ports 1-2, another for 3-4.
// - Straps A, B, C form a 3-bit code picking one address set.
// - All straps in: ports at 3F8, 2F8, 3E8, 2E8, status at 220.
// - Each port is an 8-byte block; A, B in, C out gives 100-118.
// - Status is one byte at 240-24C with C out, 220/224 with C in.
// - Straps D, E place the 4-byte parallel block at 200/240/280/300.
// - Protocol strap in selects single-ended, out selects differential transceiver.
// - Transmit-control strap in differential mode gates transmitter by request-to-send.
// - Echo strap in: transmitter enable disables the receiver.
// - Each port's request routes to any of nine levels, sharing allowed.
// - Request drives the line high, otherwise releases it; never low.
// - Status bits 3..0 show live requests of ports 4..1, shared or not.
// - Status bits 7..4 always read zero.
// - A status bit is one while its request is active, else zero.
`timescale 1ns/1ps
`default_nettype none
module sbdig_top
   import sbdig_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] isaAddr,
   input wire logic isaAen,
   input wire logic isaIorN,
   input wire logic isaIowN,
   output logic [DATA_W-1:0] isaDataOut,
   output logic isaDataOe,
   output logic [NPORT-1:0] uartCsN,
   output logic dioCsN,
   input wire sbdig_straps_t addressStrapBlock,
   input wire sbdig_port_cfg_t portProtocolStraps [NPORT],
   input wire logic oscIn,
   output logic baudClk,
   output logic baudTick,
   output logic [1:0] halfDuplexCtrlInN,
   input wire logic [NPORT-1:0] portIrqFlag,
   input wire logic [NPORT-1:0] uartTxActive,
   input wire logic [NPORT-1:0] uartSwRtsN,
   output logic [NPORT-1:0] rtsN,
   output logic [NPORT-1:0] txEnable,
   output logic [NPORT-1:0] rxEnable,
   output logic [NPORT-1:0] sel232,
   output logic [NLEVEL-1:0] irqLineOut,
   output logic [NLEVEL-1:0] irqLineOe
);
   // ==================================================
   // Pin synchronisers
   sbdig_bus_t busRaw;
   sbdig_bus_t busS;
   sbdig_straps_t strapS;
   sbdig_port_cfg_t cfgS [NPORT];
   logic oscS;
   logic [NPORT-1:0] irqS;
   logic [NPORT-1:0] txActS;
   logic [NPORT-1:0] swRtsS;

   assign busRaw = '{addr: isaAddr, aen: isaAen, iorN: isaIorN,
                     iowN: isaIowN};

   sbdig_sync #(.W($bits(sbdig_bus_t))) u_syncBus (
      .mclk(mclk),
      .reset_n(reset_n),
      .d(busRaw),
      .q(busS)
   );
   sbdig_sync #(.W($bits(sbdig_straps_t))) u_syncStrap (
      .mclk(mclk),
      .reset_n(reset_n),
      .d(addressStrapBlock),
      .q(strapS)
   );
   sbdig_sync #(.W(1 + 3 * NPORT)) u_syncMisc (
      .mclk(mclk),
      .reset_n(reset_n),
      .d({oscIn, portIrqFlag, uartTxActive, uartSwRtsN}),
      .q({oscS, irqS, txActS, swRtsS})
   );

   // ==================================================
   // Baud clock select and divider
   logic oscPrev_q;
   logic oscEdge;
   logic [OSC_DIV_W-1:0] divCnt_q;
   logic baudClk_q;
   logic baudTick_q;

   assign oscEdge = oscS && !oscPrev_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         oscPrev_q <= 1'b0;
         divCnt_q <= '0;
         baudClk_q <= 1'b0;
         baudTick_q <= 1'b0;
      end else begin
         oscPrev_q <= oscS;
         if (oscEdge) begin
            divCnt_q <= divCnt_q + 1'b1;
         end
         if (strapS.clkMult) begin
            baudClk_q <= oscS;
            baudTick_q <= oscEdge;
         end else begin
            // Square output, high for two oscillator periods
            baudClk_q <= divCnt_q > DIV_HALF;
            baudTick_q <= oscEdge && divCnt_q == DIV_LAST;
         end
      end
   end

   assign baudClk = baudClk_q;
   assign baudTick = baudTick_q;

   // ==================================================
   // Address decode
   logic [2:0] serCode;
   logic [1:0] dioCode;
   logic hostCycle;
   logic [NPORT-1:0] uartHit;
   logic statusHit;
   logic dioHit;
   logic statusRead;

   // Jumper in reads as binary zero
   assign serCode = {!strapS.addrC, !strapS.addrB, !strapS.addrA};
   assign dioCode = {!strapS.dioE, !strapS.dioD};
   // DMA cycles raise address enable; never ours
   assign hostCycle = !busS.aen && (!busS.iorN || !busS.iowN);

   for (genvar p = 0; p < NPORT; p++) begin : g_dec
      assign uartHit[p] = hostCycle &&
         busS.addr[ADDR_W-1:UART_BLK_LSB] ==
         UART_BASE[serCode][p][ADDR_W-1:UART_BLK_LSB];
   end

   assign statusHit = hostCycle &&
      busS.addr == STATUS_ADDR[serCode];
   assign dioHit = hostCycle &&
      busS.addr[ADDR_W-1:DIO_BLK_LSB] ==
      DIO_BASE[dioCode][ADDR_W-1:DIO_BLK_LSB];
   // Writes to status fall through untouched
   assign statusRead = statusHit && !busS.iorN;

   assign uartCsN = ~uartHit;
   assign dioCsN = !dioHit;

   // ==================================================
   // Status register read path
   logic [DATA_W-1:0] dataOut_q;
   logic dataOe_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dataOut_q <= DATA_IDLE;
         dataOe_q <= 1'b0;
      end else begin
         dataOe_q <= statusRead;
         if (statusRead) begin
            // Live flags, nothing latched or cleared
            dataOut_q <= {STATUS_PAD, irqS};
         end else begin
            dataOut_q <= DATA_IDLE;
         end
      end
   end

   assign isaDataOut = dataOut_q;
   assign isaDataOe = dataOe_q;

   // ==================================================
   // Half-duplex control and per-port logic
   logic [1:0] hdN_q;
   logic [NPORT-1:0] autoEn;
   logic [NLEVEL-1:0] route [NPORT];

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         hdN_q <= 2'h3;
      end else begin
         hdN_q <= {!strapS.hd34, !strapS.hd12};
      end
   end

   assign halfDuplexCtrlInN = hdN_q;
   // One control input serves both ports of a controller
   assign autoEn = {{2{strapS.hd34}}, {2{strapS.hd12}}};

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      sbdig_port u_port (
         .mclk(mclk),
         .reset_n(reset_n),
         .cfg(cfgS[p]),
         .autoEn(autoEn[p]),
         .txActive(txActS[p]),
         .swRtsN(swRtsS[p]),
         .irqFlag(irqS[p]),
         .rtsN_q(rtsN[p]),
         .txEnable_q(txEnable[p]),
         .rxEnable_q(rxEnable[p]),
         .sel232_q(sel232[p]),
         .irqRoute_q(route[p])
      );
      sbdig_sync #(.W($bits(sbdig_port_cfg_t))) u_syncCfg (
         .mclk(mclk),
         .reset_n(reset_n),
         .d(portProtocolStraps[p]),
         .q(cfgS[p])
      );
   end

   // ==================================================
   // Shared interrupt lines
   logic [NLEVEL-1:0] levelReq;

   always_comb begin
      levelReq = '0;
      for (int p = 0; p < NPORT; p++) begin
         levelReq = levelReq | route[p];
      end
   end

   // Drive high or float; low comes from the pull-down only
   assign irqLineOut = '1;
   assign irqLineOe = levelReq;

   // ==================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   property p_clk_x4;
      strapS.clkMult && $past(strapS.clkMult) |-> baudClk_q == $past(oscS);
   endproperty
   a_clk_x4: assert property (p_clk_x4)
      else $error("x4 baud clock not following oscillator");

   property p_clk_x1;
      !strapS.clkMult && baudTick_q |-> $past(divCnt_q) == DIV_LAST
         && !$past(baudTick_q);
   endproperty
   a_clk_x1: assert property (p_clk_x1)
      else $error("x1 baud tick not on fourth edge");

   property p_dec_code0;
      strapS.addrA && strapS.addrB && strapS.addrC && hostCycle
         && busS.addr == 10'h3F8 |-> !uartCsN[0] && uartCsN[3:1] == 3'h7;
   endproperty
   a_dec_code0: assert property (p_dec_code0)
      else $error("port 1 not decoded at 3F8");

   property p_dec_code4;
      strapS.addrA && strapS.addrB && !strapS.addrC && hostCycle
         && busS.addr == 10'h11F |-> !uartCsN[3] && statusHit == 1'b0;
   endproperty
   a_dec_code4: assert property (p_dec_code4)
      else $error("port 4 block end not decoded at 11F");

   property p_status_addr;
      !strapS.addrA && !strapS.addrB && !strapS.addrC && hostCycle
         && busS.addr == 10'h24C |-> statusHit;
   endproperty
   a_status_addr: assert property (p_status_addr)
      else $error("status not decoded at 24C");

   property p_dio_addr;
      !strapS.dioD && strapS.dioE && hostCycle
         && busS.addr == 10'h243 |-> !dioCsN;
   endproperty
   a_dio_addr: assert property (p_dio_addr)
      else $error("parallel block not decoded at 240");

   property p_status_read;
      statusRead |=> isaDataOe && isaDataOut == {4'h0, $past(irqS)};
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read data wrong");

   property p_status_high;
      isaDataOut[7:4] == 4'h0;
   endproperty
   a_status_high: assert property (p_status_high)
      else $error("status upper bits not zero");

   property p_status_write;
      statusHit && busS.iorN |=> !isaDataOe;
   endproperty
   a_status_write: assert property (p_status_write)
      else $error("status write produced a drive");

   property p_irq_share;
      irqS[0] |=> (irqLineOe & $past(cfgS[0].irqLevel))
         == $past(cfgS[0].irqLevel) && irqLineOut == '1;
   endproperty
   a_irq_share: assert property (p_irq_share)
      else $error("requested level not driven high");

   property p_auto_rts;
      autoEn[1] && txActS[1] |=> !rtsN[1];
   endproperty
   a_auto_rts: assert property (p_auto_rts)
      else $error("auto request-to-send not low");

   property p_echo;
      $past(cfgS[0].echo) && txEnable[0] |-> !rxEnable[0];
   endproperty
   a_echo: assert property (p_echo)
      else $error("receiver left on while transmitting");

   c_status_read: cover property (statusRead ##1 isaDataOut[0]);
   c_shared_irq: cover property (irqS[0] && irqS[1]
      && cfgS[0].irqLevel == cfgS[1].irqLevel);
   c_x1_tick: cover property (!strapS.clkMult && baudTick_q);
   c_auto_tx: cover property (autoEn[0] && txEnable[0] && !rtsN[0]);
endmodule : sbdig_top
`default_nettype wire

//--- common/sbdig_pkg.sv
/*
 Constants, address tables and carrier types for the serial board glue.
 Assumes a 10-bit byte I/O address space and four serial ports.
*/
package sbdig_pkg;
   // ==================================================
   // Sizes
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int NPORT = 4;
   localparam int NLEVEL = 9;
   localparam int UART_BLK_LSB = 3;
   localparam int DIO_BLK_LSB = 2;
   // ==================================================
   // Baud clock
   localparam int OSC_DIV = 4;
   localparam int OSC_DIV_W = 2;
   localparam logic [OSC_DIV_W-1:0] DIV_LAST = 2'h3;
   localparam logic [OSC_DIV_W-1:0] DIV_HALF = 2'h1;
   // ==================================================
   // Status register layout
   localparam logic [3:0] STATUS_PAD = 4'h0;
   localparam logic [DATA_W-1:0] DATA_IDLE = 8'h00;
   // ==================================================
   // Address tables, index {C out, B out, A out}
   typedef logic [ADDR_W-1:0] sbdig_addr_t;
   localparam sbdig_addr_t UART_BASE [8][NPORT] = '{
      '{10'h3F8, 10'h2F8, 10'h3E8, 10'h2E8},
      '{10'h3E8, 10'h2E8, 10'h3A8, 10'h2A8},
      '{10'h380, 10'h388, 10'h288, 10'h230},
      '{10'h240, 10'h248, 10'h260, 10'h268},
      '{10'h100, 10'h108, 10'h110, 10'h118},
      '{10'h120, 10'h128, 10'h130, 10'h138},
      '{10'h140, 10'h148, 10'h150, 10'h158},
      '{10'h160, 10'h168, 10'h170, 10'h178}};
   localparam sbdig_addr_t STATUS_ADDR [8] = '{10'h220, 10'h220,
      10'h224, 10'h224, 10'h240, 10'h244, 10'h248, 10'h24C};
   // Index {E out, D out}
   localparam sbdig_addr_t DIO_BASE [4] = '{10'h200, 10'h240,
      10'h280, 10'h300};
   // Level carried by each bit of an interrupt level vector
   localparam int IRQ_LEVEL_NUM [NLEVEL] = '{2, 3, 4, 5, 6, 7, 10, 12, 15};
   // ==================================================
   // Carriers; strap fields are 1 when the jumper is in
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic aen;
      logic iorN;
      logic iowN;
   } sbdig_bus_t;
   typedef struct packed {
      logic clkMult;
      logic addrA;
      logic addrB;
      logic addrC;
      logic dioD;
      logic dioE;
      logic hd12;
      logic hd34;
   } sbdig_straps_t;
   typedef struct packed {
      logic sel232;
      logic rtsCtrl;
      logic echo;
      logic [NLEVEL-1:0] irqLevel;
   } sbdig_port_cfg_t;
endpackage : sbdig_pkg

//--- design/sbdig_sync.sv
/*
 Two-stage synchroniser for a vector of pin levels.
 Assumes inputs are quasi-static or level signals from outside mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sbdig_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   // ==================================================
   // First stage feeds only the second
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : sbdig_sync
`default_nettype wire

//--- design/sbdig_port.sv
/*
 Per-port half-duplex, transceiver select, echo and interrupt routing.
 Assumes all inputs are already synchronised to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sbdig_port
   import sbdig_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire sbdig_port_cfg_t cfg,
   input wire logic autoEn,
   input wire logic txActive,
   input wire logic swRtsN,
   input wire logic irqFlag,
   output logic rtsN_q,
   output logic txEnable_q,
   output logic rxEnable_q,
   output logic sel232_q,
   output logic [NLEVEL-1:0] irqRoute_q
);
   logic rtsN_d;
   logic txEnable_d;
   logic gateByRts;
   // ==================================================
   // Request-to-send and transceiver gating
   assign rtsN_d = autoEn ? !txActive : swRtsN;
   assign gateByRts = !cfg.sel232 && cfg.rtsCtrl;
   assign txEnable_d = gateByRts ? !rtsN_d : 1'b1;
   // ==================================================
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rtsN_q <= 1'b1;
         txEnable_q <= 1'b0;
         rxEnable_q <= 1'b1;
         sel232_q <= 1'b1;
         irqRoute_q <= '0;
      end else begin
         rtsN_q <= rtsN_d;
         txEnable_q <= txEnable_d;
         // Echo suppression follows the enable being driven
         rxEnable_q <= !(cfg.echo && txEnable_d);
         sel232_q <= cfg.sel232;
         irqRoute_q <= irqFlag ? cfg.irqLevel : '0;
      end
   end
endmodule : sbdig_port
`default_nettype wire

//--- test/sbdig_host_model.sv
/*
 Host processor model: 8-bit I/O read and write cycles on the bus.
 Assumes the bench clock and the glue's select and data returns.
*/
`timescale 1ns/1ps
`default_nettype none
module sbdig_host_model
   import sbdig_pkg::*;
(
   input wire logic mclk,
   output logic [ADDR_W-1:0] isaAddr,
   output logic isaAen,
   output logic isaIorN,
   output logic isaIowN,
   input wire logic [DATA_W-1:0] isaDataOut,
   input wire logic isaDataOe,
   input wire logic [NPORT-1:0] uartCsN,
   input wire logic dioCsN
);
   initial begin
      isaAddr = 10'h000;
      isaAen = 1'b0;
      isaIorN = 1'b1;
      isaIowN = 1'b1;
   end
   // ==========
   // Bus cycle
   // Strobe held 5 edges, gap 4: spacing limits of the glue kept
   task automatic io(input logic wr, input logic aen,
      input logic [ADDR_W-1:0] a, output logic [13:0] res);
      @(negedge mclk);
      isaAddr = a;
      isaAen = aen;
      isaIorN = wr;
      isaIowN = !wr;
      repeat (5) @(posedge mclk);
      // Sample settled returns, then release in the same step
      @(negedge mclk);
      res = {isaDataOe, isaDataOut, dioCsN, uartCsN};
      isaIorN = 1'b1;
      isaIowN = 1'b1;
      // Idle address never repeats the last one
      isaAddr = ~a;
      isaAen = 1'b0;
      repeat (4) @(negedge mclk);
   endtask : io
endmodule : sbdig_host_model
`default_nettype wire

//--- test/tb_top.sv
/*
 Self-checking bench for the serial board glue.
 Assumes the host model file and the design package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sbdig_pkg::*;
   logic mclk, reset_n, oscIn;
   wire logic [ADDR_W-1:0] isaAddr;
   wire logic isaAen, isaIorN, isaIowN, isaDataOe, dioCsN;
   wire logic baudClk, baudTick;
   wire logic [DATA_W-1:0] isaDataOut;
   wire logic [1:0] hdN;
   wire logic [NPORT-1:0] csN, rtsN, txEn, rxEn, sel232;
   wire logic [NLEVEL-1:0] irqOut, irqOe;
   sbdig_straps_t straps;
   sbdig_port_cfg_t cfg [NPORT];
   logic [NPORT-1:0] irqFlag, txAct, swRtsN;
   logic [13:0] r;
   int numErrors = 0;
   int numChecks = 0;
   localparam logic [9:0] EXP [8][5] = '{
      '{10'h3F8, 10'h2F8, 10'h3E8, 10'h2E8, 10'h220},
      '{10'h3E8, 10'h2E8, 10'h3A8, 10'h2A8, 10'h220},
      '{10'h380, 10'h388, 10'h288, 10'h230, 10'h224},
      '{10'h240, 10'h248, 10'h260, 10'h268, 10'h224},
      '{10'h100, 10'h108, 10'h110, 10'h118, 10'h240},
      '{10'h120, 10'h128, 10'h130, 10'h138, 10'h244},
      '{10'h140, 10'h148, 10'h150, 10'h158, 10'h248},
      '{10'h160, 10'h168, 10'h170, 10'h178, 10'h24C}};
   localparam logic [9:0] DIO [4] = '{10'h200, 10'h240, 10'h280,
      10'h300};
   sbdig_host_model u_host (.mclk(mclk), .isaAddr(isaAddr),
      .isaAen(isaAen), .isaIorN(isaIorN), .isaIowN(isaIowN),
      .isaDataOut(isaDataOut), .isaDataOe(isaDataOe),
      .uartCsN(csN), .dioCsN(dioCsN));
   sbdig_top u_dut (.mclk(mclk), .reset_n(reset_n),
      .isaAddr(isaAddr), .isaAen(isaAen), .isaIorN(isaIorN),
      .isaIowN(isaIowN), .isaDataOut(isaDataOut),
      .isaDataOe(isaDataOe), .uartCsN(csN), .dioCsN(dioCsN),
      .addressStrapBlock(straps), .portProtocolStraps(cfg),
      .oscIn(oscIn), .baudClk(baudClk), .baudTick(baudTick),
      .halfDuplexCtrlInN(hdN), .portIrqFlag(irqFlag),
      .uartTxActive(txAct), .uartSwRtsN(swRtsN), .rtsN(rtsN),
      .txEnable(txEn), .rxEnable(rxEn), .sel232(sel232),
      .irqLineOut(irqOut), .irqLineOe(irqOe));
   // ==========
   // Clock, oscillator, watchdog
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      oscIn = 1'b0;
      forever begin
         repeat (4) @(negedge mclk);
         oscIn = ~oscIn;
      end
   end
   initial begin
      #400us;
      numErrors++;
      tally_and_finish();
   end
   // ==========
   // Helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      numChecks++;
      if (seen !== exp) begin
         numErrors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(negedge mclk);
   endtask : w
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish
   // ==========
   // Scenarios
   task automatic t_decode();
      for (int c = 0; c < 8; c++) begin
         straps.addrA = !c[0];
         straps.addrB = !c[1];
         straps.addrC = !c[2];
         w(4);
         for (int p = 0; p < 4; p++) begin
            u_host.io(1'b0, 1'b0, EXP[c][p], r);
            chk(r[3:0], 4'(~(4'h1 << p)));
            u_host.io(1'b0, 1'b0, EXP[c][p] + 10'h007, r);
            chk(r[3:0], 4'(~(4'h1 << p)));
         end
         u_host.io(1'b0, 1'b0, EXP[c][4], r);
         chk(r[13:4], {1'b1, 8'h00, 1'b1});
         u_host.io(1'b0, 1'b0, EXP[c][4] + 10'h001, r);
         chk(r[13], 1'b0);
         u_host.io(1'b0, 1'b1, EXP[c][0], r);
         chk(r[3:0], 4'hF);
      end
   endtask : t_decode
   task automatic t_dio();
      straps.addrA = 1'b1;
      straps.addrB = 1'b1;
      straps.addrC = 1'b1;
      for (int d = 0; d < 4; d++) begin
         straps.dioD = !d[0];
         straps.dioE = !d[1];
         w(4);
         u_host.io(1'b0, 1'b0, DIO[d], r);
         chk(r[4], 1'b0);
         u_host.io(1'b1, 1'b0, DIO[d] + 10'h003, r);
         chk(r[4], 1'b0);
         u_host.io(1'b0, 1'b0, DIO[d] + 10'h004, r);
         chk(r[4], 1'b1);
      end
   endtask : t_dio
   task automatic t_baud(input logic mult, input int exp);
      int ticks;
      int rises;
      logic prev;
      ticks = 0;
      rises = 0;
      straps.clkMult = mult;
      w(24);
      prev = baudClk;
      repeat (320) begin
         @(negedge mclk);
         ticks += int'(baudTick === 1'b1);
         rises += int'(baudClk === 1'b1 && prev === 1'b0);
         prev = baudClk;
      end
      chk(ticks, exp);
      chk(rises, exp);
   endtask : t_baud
   task automatic t_irq();
      for (int l = 0; l < NLEVEL; l++) begin
         cfg[0].irqLevel = 9'h001 << l;
         irqFlag = 4'h1;
         w(5);
         chk(irqOe, 9'h001 << l);
         chk(irqOut, 9'h1FF);
         irqFlag = 4'h0;
         w(5);
         chk(irqOe, 9'h000);
      end
      cfg[0].irqLevel = 9'h002;
      cfg[1].irqLevel = 9'h002;
      cfg[2].irqLevel = 9'h040;
      cfg[3].irqLevel = 9'h100;
      irqFlag = 4'h3;
      w(5);
      chk(irqOe, 9'h002);
      u_host.io(1'b0, 1'b0, 10'h220, r);
      chk(r[13:5], {1'b1, 8'h03});
      irqFlag = 4'hE;
      u_host.io(1'b1, 1'b0, 10'h220, r);
      chk(r[13], 1'b0);
      chk(irqOe, 9'h142);
      u_host.io(1'b0, 1'b0, 10'h220, r);
      chk(r[12:5], 8'h0E);
      u_host.io(1'b0, 1'b0, 10'h220, r);
      chk(r[12:5], 8'h0E);
      irqFlag = 4'h0;
      u_host.io(1'b0, 1'b0, 10'h220, r);
      chk(r[12:5], 8'h00);
   endtask : t_irq
   task automatic t_hd();
      straps.hd12 = 1'b1;
      straps.hd34 = 1'b0;
      cfg[0].sel232 = 1'b0;
      cfg[0].rtsCtrl = 1'b1;
      cfg[0].echo = 1'b1;
      cfg[2].rtsCtrl = 1'b1;
      w(5);
      chk(hdN, 2'b10);
      chk(sel232, 4'b0010);
      chk(txEn, 4'b1010);
      chk(rxEn, 4'b1111);
      txAct = 4'b0111;
      w(5);
      chk(rtsN, 4'b1100);
      chk(txEn, 4'b1011);
      chk(rxEn, 4'b1110);
      txAct = 4'b0000;
      swRtsN = 4'b0000;
      w(5);
      chk(rtsN, 4'b0011);
      chk(txEn, 4'b1110);
      straps.hd12 = 1'b0;
      straps.hd34 = 1'b1;
      txAct = 4'b0100;
      swRtsN = 4'b1111;
      w(5);
      chk(hdN, 2'b01);
      chk(rtsN, 4'b1011);
   endtask : t_hd
   // ==========
   // Main sequence
   initial begin
      reset_n = 1'b0;
      straps = 8'h00;
      irqFlag = 4'h0;
      txAct = 4'h0;
      swRtsN = 4'hF;
      for (int i = 0; i < NPORT; i++) begin
         cfg[i] = '{sel232: 1'b1, rtsCtrl: 1'b0, echo: 1'b0,
            irqLevel: 9'h000};
      end
      cfg[1].sel232 = 1'b1;
      cfg[2].sel232 = 1'b0;
      cfg[3].sel232 = 1'b0;
      w(16);
      chk({irqOe, isaDataOe, hdN}, {9'h000, 1'b0, 2'b11});
      reset_n = 1'b1;
      w(4);
      t_decode();
      t_dio();
      t_baud(1'b0, 10);
      t_baud(1'b1, 40);
      t_irq();
      t_hd();
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
